// File: ddr2_config_timing_regs.sv
// ddr2 configuration and timing registers with a command spacing scheduler
module ddr2_config_timing_regs #(
  parameter int LAT_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ddr_timing_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire ddr_timing_pkg::cmd_req_t cmd_req,
  output ddr_timing_pkg::cmd_req_t cmd_issue,
  output logic read_data_due,
  output ddr_timing_pkg::geometry_t geometry
);

  typedef struct packed {
    logic [31:0] geo;
    logic [31:0] ta;
    logic [31:0] tb;
    logic [31:0] tc;
    logic [31:0] ctl;
    logic [31:0] rdata;
    logic [ddr_timing_pkg::NUM_C-1:0][7:0] cnt;
    logic [ddr_timing_pkg::NUM_FAW-1:0][7:0] faw;
    logic [1:0] faw_ptr;
    logic [LAT_DEPTH-1:0] lat_sh;
    ddr_timing_pkg::cmd_req_t issue;
    logic due;
    ddr_timing_pkg::geometry_t geom;
  } state_t;

  state_t state_q;
  state_t state_d;

  // pick a field of up to eight bits out of a register
  function automatic logic [7:0] fld(input logic [31:0] r, input int lsb, input int w);
    logic [31:0] sh;
    sh = r >> lsb;
    fld = sh[7:0] & 8'((9'h001 << w) - 9'h001);
  endfunction : fld

  // a spacing counter is satisfied from its final cycle onward
  function automatic logic done(input logic [7:0] c);
    done = (c <= 8'h01);
  endfunction : done

  logic [ddr_timing_pkg::NUM_C-1:0] ok;
  logic faw_free;
  logic allow_any;
  logic allow;
  logic take;
  logic [7:0] wtr_load;

  always_comb
  begin
    for (int i = 0; i < ddr_timing_pkg::NUM_C; i++)
    begin
      ok[i] = done(state_q.cnt[i]);
    end
  end

  // four-activate window only applies to eight-bank parts
  always_comb
  begin
    faw_free = !state_q.geo[ddr_timing_pkg::GEO_BANKS8];
    for (int i = 0; i < ddr_timing_pkg::NUM_FAW; i++)
    begin
      if (done(state_q.faw[i]))
      begin
        faw_free = 1'b1;
      end
    end
  end

  // precharge, precharge-all and power-down exit hold off every command except the three exit commands
  assign allow_any = ok[ddr_timing_pkg::C_RP] & ok[ddr_timing_pkg::C_RPA]
    & ok[ddr_timing_pkg::C_XP];

  always_comb
  begin
    allow = 1'b0;
    case (cmd_req.cmd)
      ddr_timing_pkg::CMD_ACT:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_RRD]
          & ok[ddr_timing_pkg::C_MRD]
          & ok[ddr_timing_pkg::C_RFC]
          & ok[ddr_timing_pkg::C_XSNR]
          & faw_free;
      end
      ddr_timing_pkg::CMD_READ:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_RCD]
          & ok[ddr_timing_pkg::C_WTR]
          & ok[ddr_timing_pkg::C_XSRD]
          & ok[ddr_timing_pkg::C_XARD];
      end
      ddr_timing_pkg::CMD_WRITE:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_RCD] & ok[ddr_timing_pkg::C_XSNR];
      end
      ddr_timing_pkg::CMD_PRE, ddr_timing_pkg::CMD_PRE_ALL:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_RAS]
          & ok[ddr_timing_pkg::C_WR]
          & ok[ddr_timing_pkg::C_RTP]
          & ok[ddr_timing_pkg::C_XSNR];
      end
      ddr_timing_pkg::CMD_REFRESH:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_RC]
          & ok[ddr_timing_pkg::C_MRD]
          & ok[ddr_timing_pkg::C_RFC]
          & ok[ddr_timing_pkg::C_XSNR];
      end
      ddr_timing_pkg::CMD_LOAD_MODE:
      begin
        allow = allow_any & ok[ddr_timing_pkg::C_XSNR];
      end
      ddr_timing_pkg::CMD_PD_EXIT, ddr_timing_pkg::CMD_ACTIVE_PD_EXIT,
      ddr_timing_pkg::CMD_SELFREF_EXIT:
      begin
        allow = 1'b1;
      end
      default:
      begin
        allow = 1'b0;
      end
    endcase
  end

  assign take = cmd_req.valid & allow;

  // reduced spacing removes the gap only while the field is zero
  always_comb
  begin
    wtr_load = fld(state_q.ta, ddr_timing_pkg::TA_WTR_LSB, ddr_timing_pkg::TA_WTR_W);
    if (wtr_load == 8'h00)
    begin
      wtr_load = state_q.ta[ddr_timing_pkg::TA_RDC] ? 8'h00 : 8'h02;
    end
  end

  always_comb
  begin
    state_d = state_q;
    state_d.rdata = 32'h00000000;

    // register writes
    if (reg_req.wr)
    begin
      if (reg_req.addr == ddr_timing_pkg::OFS_GEOMETRY)
      begin
        state_d.geo = reg_req.wdata & ddr_timing_pkg::GEO_WMASK;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_A)
      begin
        state_d.ta = reg_req.wdata;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_B)
      begin
        state_d.tb = reg_req.wdata & ddr_timing_pkg::TB_WMASK;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_C)
      begin
        state_d.tc = reg_req.wdata & ddr_timing_pkg::TC_WMASK;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_CONTROL)
      begin
        state_d.ctl = {31'h00000000, reg_req.wdata[ddr_timing_pkg::CTL_SLOW_EXIT]};
      end
    end

    // register reads, data in the following cycle, unmapped reads zero
    if (reg_req.rd)
    begin
      if (reg_req.addr == ddr_timing_pkg::OFS_GEOMETRY)
      begin
        state_d.rdata = state_q.geo;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_A)
      begin
        state_d.rdata = state_q.ta;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_B)
      begin
        state_d.rdata = state_q.tb;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_TIMING_C)
      begin
        state_d.rdata = state_q.tc;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_CONTROL)
      begin
        state_d.rdata = state_q.ctl;
      end
      else if (reg_req.addr == ddr_timing_pkg::OFS_STATUS)
      begin
        state_d.rdata = {16'h0000, faw_free, ~ok};
      end
    end

    // counters run down every cycle
    for (int i = 0; i < ddr_timing_pkg::NUM_C; i++)
    begin
      if (state_q.cnt[i] != 8'h00)
      begin
        state_d.cnt[i] = state_q.cnt[i] - 8'h01;
      end
    end
    for (int i = 0; i < ddr_timing_pkg::NUM_FAW; i++)
    begin
      if (state_q.faw[i] != 8'h00)
      begin
        state_d.faw[i] = state_q.faw[i] - 8'h01;
      end
    end

    // read latency pipeline
    state_d.lat_sh = {state_q.lat_sh[LAT_DEPTH-2:0], 1'b0};
    state_d.due = state_q.lat_sh[state_q.geo[ddr_timing_pkg::GEO_LAT_LSB +: 3]];

    state_d.issue = '0;
    if (take)
    begin
      state_d.issue = cmd_req;
      case (cmd_req.cmd)
        ddr_timing_pkg::CMD_ACT:
        begin
          state_d.cnt[ddr_timing_pkg::C_RAS] = fld(state_q.ta, ddr_timing_pkg::TA_RAS_LSB,
            ddr_timing_pkg::NIB_W);
          state_d.cnt[ddr_timing_pkg::C_RCD] = fld(state_q.ta, ddr_timing_pkg::TA_RCD_LSB,
            ddr_timing_pkg::NIB_W);
          state_d.cnt[ddr_timing_pkg::C_RC] = fld(state_q.ta, ddr_timing_pkg::TA_RC_LSB,
            ddr_timing_pkg::NIB_W);
          state_d.cnt[ddr_timing_pkg::C_RRD] = fld(state_q.ta, ddr_timing_pkg::TA_RRD_LSB,
            ddr_timing_pkg::NIB_W);
          if (state_q.geo[ddr_timing_pkg::GEO_BANKS8])
          begin
            state_d.faw[state_q.faw_ptr] = fld(state_q.tc, ddr_timing_pkg::TC_FAW_LSB,
              ddr_timing_pkg::BYTE_W);
            state_d.faw_ptr = state_q.faw_ptr + 2'h1;
          end
        end
        ddr_timing_pkg::CMD_READ:
        begin
          state_d.cnt[ddr_timing_pkg::C_RTP] = fld(state_q.tc, ddr_timing_pkg::TC_RTP_LSB,
            ddr_timing_pkg::TC_RTP_W);
          state_d.lat_sh[0] = 1'b1;
        end
        ddr_timing_pkg::CMD_WRITE:
        begin
          state_d.cnt[ddr_timing_pkg::C_WR] = fld(state_q.ta, ddr_timing_pkg::TA_WR_LSB,
            ddr_timing_pkg::NIB_W);
          state_d.cnt[ddr_timing_pkg::C_WTR] = wtr_load;
        end
        ddr_timing_pkg::CMD_PRE:
        begin
          state_d.cnt[ddr_timing_pkg::C_RP] = fld(state_q.ta, ddr_timing_pkg::TA_RP_LSB,
            ddr_timing_pkg::NIB_W);
        end
        ddr_timing_pkg::CMD_PRE_ALL:
        begin
          state_d.cnt[ddr_timing_pkg::C_RPA] = fld(state_q.tc, ddr_timing_pkg::TC_RPA_LSB,
            ddr_timing_pkg::NIB_W);
        end
        ddr_timing_pkg::CMD_REFRESH:
        begin
          state_d.cnt[ddr_timing_pkg::C_RFC] = fld(state_q.tb, ddr_timing_pkg::TB_RFC_LSB,
            ddr_timing_pkg::TB_RFC_W);
        end
        ddr_timing_pkg::CMD_LOAD_MODE:
        begin
          state_d.cnt[ddr_timing_pkg::C_MRD] = fld(state_q.ta, ddr_timing_pkg::TA_MRD_LSB,
            ddr_timing_pkg::NIB_W);
        end
        ddr_timing_pkg::CMD_PD_EXIT:
        begin
          state_d.cnt[ddr_timing_pkg::C_XP] = fld(state_q.tb, ddr_timing_pkg::TB_XP_LSB,
            ddr_timing_pkg::NIB_W);
        end
        ddr_timing_pkg::CMD_ACTIVE_PD_EXIT:
        begin
          if (state_q.ctl[ddr_timing_pkg::CTL_SLOW_EXIT])
          begin
            state_d.cnt[ddr_timing_pkg::C_XARD] = fld(state_q.tc,
              ddr_timing_pkg::TC_XARDS_LSB, ddr_timing_pkg::NIB_W);
          end
          else
          begin
            state_d.cnt[ddr_timing_pkg::C_XARD] = fld(state_q.tc,
              ddr_timing_pkg::TC_XARD_LSB, ddr_timing_pkg::NIB_W);
          end
        end
        ddr_timing_pkg::CMD_SELFREF_EXIT:
        begin
          state_d.cnt[ddr_timing_pkg::C_XSRD] = fld(state_q.tb, ddr_timing_pkg::TB_XSRD_LSB,
            ddr_timing_pkg::BYTE_W);
          state_d.cnt[ddr_timing_pkg::C_XSNR] = fld(state_q.tb, ddr_timing_pkg::TB_XSNR_LSB,
            ddr_timing_pkg::BYTE_W);
        end
        default:
        begin
          state_d.issue = '0;
        end
      endcase
    end

    // geometry and mode bits presented to the memory side
    state_d.geom.col_count = ddr_timing_pkg::COL_BASE
      + 5'(fld(state_q.geo, ddr_timing_pkg::GEO_COL_LSB, ddr_timing_pkg::GEO_COL_W));
    state_d.geom.row_count = ddr_timing_pkg::ROW_BASE
      + 5'(fld(state_q.geo, ddr_timing_pkg::GEO_ROW_LSB, ddr_timing_pkg::GEO_ROW_W));
    state_d.geom.read_latency = state_q.geo[ddr_timing_pkg::GEO_LAT_LSB +: 3];
    state_d.geom.dll_reset_ctl = state_q.geo[ddr_timing_pkg::GEO_DLL_RESET];
    state_d.geom.drive_strength_sel = state_q.geo[ddr_timing_pkg::GEO_DRIVE];
    state_d.geom.dll_disable = state_q.geo[ddr_timing_pkg::GEO_DLL_DIS];
    state_d.geom.impedance_cal = state_q.geo[ddr_timing_pkg::GEO_ZQ_LSB +: 2];
    state_d.geom.driver_cal = state_q.geo[ddr_timing_pkg::GEO_OCD_LSB +: 3];
    state_d.geom.mask_shared = state_q.geo[ddr_timing_pkg::GEO_MASK_SHARED];
    state_d.geom.read_measure_en = state_q.geo[ddr_timing_pkg::GEO_RD_MEASURE];
    state_d.geom.bank_count = state_q.geo[ddr_timing_pkg::GEO_BANKS8];
    state_d.geom.diff_strobe_disable = state_q.geo[ddr_timing_pkg::GEO_DIFF_DIS];
    state_d.geom.address_decoding = state_q.geo[ddr_timing_pkg::GEO_DECODE];
    state_d.geom.unaligned_support = state_q.geo[ddr_timing_pkg::GEO_UNALIGNED];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.geo <= ddr_timing_pkg::RST_GEOMETRY;
      state_q.ta <= ddr_timing_pkg::RST_TIMING_A;
      state_q.tb <= ddr_timing_pkg::RST_TIMING_B;
      state_q.tc <= ddr_timing_pkg::RST_TIMING_C;
      state_q.ctl <= ddr_timing_pkg::RST_CONTROL;
      state_q.geom <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign cmd_issue = state_q.issue;
  assign read_data_due = state_q.due;
  assign geometry = state_q.geom;

endmodule : ddr2_config_timing_regs

// File: ddr_timing_pkg.sv
// shared constants and types for the ddr2 configuration and timing block
package ddr_timing_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_GEOMETRY = 8'h00;
  localparam logic [7:0] OFS_TIMING_A = 8'h04;
  localparam logic [7:0] OFS_TIMING_B = 8'h08;
  localparam logic [7:0] OFS_TIMING_C = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // reset values
  localparam logic [31:0] RST_GEOMETRY = 32'h00207024;
  localparam logic [31:0] RST_TIMING_A = 32'h00000000;
  localparam logic [31:0] RST_TIMING_B = 32'h00000000;
  localparam logic [31:0] RST_TIMING_C = 32'h00000000;
  localparam logic [31:0] RST_CONTROL = 32'h00000000;

  // geometry register fields: lsb and width
  localparam int GEO_COL_LSB = 0;
  localparam int GEO_COL_W = 2;
  localparam int GEO_ROW_LSB = 2;
  localparam int GEO_ROW_W = 2;
  localparam int GEO_LAT_LSB = 4;
  localparam int GEO_LAT_W = 3;
  localparam int GEO_DLL_RESET = 7;
  localparam int GEO_DRIVE = 8;
  localparam int GEO_DLL_DIS = 9;
  localparam int GEO_ZQ_LSB = 10;
  localparam int GEO_ZQ_W = 2;
  localparam int GEO_OCD_LSB = 12;
  localparam int GEO_OCD_W = 3;
  localparam int GEO_MASK_SHARED = 16;
  localparam int GEO_RD_MEASURE = 17;
  localparam int GEO_BANKS8 = 20;
  localparam int GEO_DIFF_DIS = 21;
  localparam int GEO_DECODE = 22;
  localparam int GEO_UNALIGNED = 23;
  localparam logic [31:0] GEO_WMASK = 32'h00f37fff;

  // timing register a
  localparam int TA_RAS_LSB = 0;
  localparam int TA_RCD_LSB = 4;
  localparam int TA_WR_LSB = 8;
  localparam int TA_RC_LSB = 12;
  localparam int TA_RP_LSB = 16;
  localparam int TA_RRD_LSB = 20;
  localparam int TA_WTR_LSB = 24;
  localparam int TA_WTR_W = 3;
  localparam int TA_RDC = 27;
  localparam int TA_MRD_LSB = 28;
  localparam int NIB_W = 4;
  // timing register b
  localparam int TB_RFC_LSB = 0;
  localparam int TB_RFC_W = 7;
  localparam int TB_XSNR_LSB = 8;
  localparam int TB_XSRD_LSB = 16;
  localparam int BYTE_W = 8;
  localparam int TB_XP_LSB = 24;
  localparam logic [31:0] TB_WMASK = 32'h0fffff7f;
  // timing register c
  localparam int TC_XARD_LSB = 0;
  localparam int TC_XARDS_LSB = 4;
  localparam int TC_RPA_LSB = 8;
  localparam int TC_RTP_LSB = 12;
  localparam int TC_RTP_W = 3;
  localparam int TC_FAW_LSB = 16;
  localparam logic [31:0] TC_WMASK = 32'h00ff7fff;
  // control register
  localparam int CTL_SLOW_EXIT = 0;

  // base widths for address counts
  localparam logic [4:0] COL_BASE = 5'h08;
  localparam logic [4:0] ROW_BASE = 5'h0b;

  // constraint counter indices
  localparam int C_RAS = 0;
  localparam int C_RCD = 1;
  localparam int C_WR = 2;
  localparam int C_RC = 3;
  localparam int C_RP = 4;
  localparam int C_RRD = 5;
  localparam int C_WTR = 6;
  localparam int C_MRD = 7;
  localparam int C_XP = 8;
  localparam int C_XSRD = 9;
  localparam int C_XSNR = 10;
  localparam int C_RFC = 11;
  localparam int C_RTP = 12;
  localparam int C_RPA = 13;
  localparam int C_XARD = 14;
  localparam int NUM_C = 15;
  localparam int NUM_FAW = 4;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_PRE_ALL, CMD_REFRESH,
    CMD_LOAD_MODE, CMD_PD_EXIT, CMD_ACTIVE_PD_EXIT, CMD_SELFREF_EXIT
  } cmd_t;

  typedef struct packed {
    logic valid;
    cmd_t cmd;
    logic [2:0] bank;
  } cmd_req_t;

  typedef struct packed {
    logic [4:0] col_count;
    logic [4:0] row_count;
    logic [2:0] read_latency;
    logic dll_reset_ctl;
    logic drive_strength_sel;
    logic dll_disable;
    logic [1:0] impedance_cal;
    logic [2:0] driver_cal;
    logic mask_shared;
    logic read_measure_en;
    logic bank_count;
    logic diff_strobe_disable;
    logic address_decoding;
    logic unaligned_support;
  } geometry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : ddr_timing_pkg

// File: ddr2_config_timing_asserts.sv
// concurrent checks on the ports of the ddr2 configuration and timing block
module ddr2_config_timing_asserts #(
  parameter int LAT_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ddr_timing_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire ddr_timing_pkg::cmd_req_t cmd_req,
  input wire ddr_timing_pkg::cmd_req_t cmd_issue,
  input wire logic read_data_due,
  input wire ddr_timing_pkg::geometry_t geometry
);
  logic [31:0] ta_q;
  logic [6:0] rfc_q;
  logic [7:0] act_q;
  logic [7:0] pre_q;
  logic [7:0] ref_q;
  logic [7:0] rd_q;
  logic is_read;
  logic exit_cmd;
  logic due_exp;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  assign is_read = cmd_issue.valid && (cmd_issue.cmd == ddr_timing_pkg::CMD_READ);
  assign exit_cmd = cmd_issue.cmd inside {ddr_timing_pkg::CMD_PD_EXIT,
    ddr_timing_pkg::CMD_ACTIVE_PD_EXIT, ddr_timing_pkg::CMD_SELFREF_EXIT};
  // the due pulse trails the visible read issue by latency plus one cycle
  assign due_exp = rd_q[geometry.read_latency];
  // cycles since the last issue of a command, saturating
  function automatic logic [7:0] bump(input logic [7:0] c, input logic hit);
    return hit ? 8'h01 : ((c == 8'hff) ? c : c + 8'h01);
  endfunction : bump
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ta_q <= 32'h0;
      rfc_q <= 7'h0;
      act_q <= 8'hff;
      pre_q <= 8'hff;
      ref_q <= 8'hff;
      rd_q <= 8'h0;
    end
    else
    begin
      if (reg_req.wr && reg_req.addr == ddr_timing_pkg::OFS_TIMING_A)
        ta_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ddr_timing_pkg::OFS_TIMING_B)
        rfc_q <= reg_req.wdata[6:0];
      act_q <= bump(act_q, cmd_issue.valid && cmd_issue.cmd == ddr_timing_pkg::CMD_ACT);
      pre_q <= bump(pre_q, cmd_issue.valid && cmd_issue.cmd == ddr_timing_pkg::CMD_PRE);
      ref_q <= bump(ref_q, cmd_issue.valid && cmd_issue.cmd == ddr_timing_pkg::CMD_REFRESH);
      rd_q <= {rd_q[6:0], is_read};
    end
  end
  a_rdata_idle:
    assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_no_nop:
    assert property (cmd_issue.valid |-> cmd_issue.cmd != ddr_timing_pkg::CMD_NOP)
    else $error("nop issued");
  a_issue_cause:
    assert property (cmd_issue.valid |-> $past(cmd_req) == cmd_issue)
    else $error("issued command without matching request");
  a_geo_size:
    assert property (reg_req.wr && reg_req.addr == ddr_timing_pkg::OFS_GEOMETRY |-> ##2
      {geometry.col_count, geometry.row_count, geometry.read_latency} ==
      {ddr_timing_pkg::COL_BASE + {3'h0, $past(reg_req.wdata[1:0], 2)},
      ddr_timing_pkg::ROW_BASE + {3'h0, $past(reg_req.wdata[3:2], 2)},
      $past(reg_req.wdata[6:4], 2)})
    else $error("geometry size fields wrong");
  a_geo_flags:
    assert property (reg_req.wr && reg_req.addr == ddr_timing_pkg::OFS_GEOMETRY |-> ##2
      {geometry.dll_reset_ctl, geometry.drive_strength_sel, geometry.dll_disable,
      geometry.impedance_cal, geometry.driver_cal, geometry.mask_shared,
      geometry.read_measure_en, geometry.bank_count, geometry.diff_strobe_disable,
      geometry.address_decoding, geometry.unaligned_support} ==
      $past({reg_req.wdata[7], reg_req.wdata[8], reg_req.wdata[9], reg_req.wdata[11:10],
      reg_req.wdata[14:12], reg_req.wdata[16], reg_req.wdata[17],
      reg_req.wdata[20], reg_req.wdata[21], reg_req.wdata[22], reg_req.wdata[23]}, 2))
    else $error("geometry flag fields wrong");
  a_due_latency:
    assert property (read_data_due == due_exp)
    else $error("read data due at wrong cycle");
  a_rcd_gap:
    assert property (is_read |-> act_q >= {4'h0, ta_q[7:4]})
    else $error("read too soon after activate");
  a_ras_gap:
    assert property (cmd_issue.valid && cmd_issue.cmd == ddr_timing_pkg::CMD_PRE
      |-> act_q >= {4'h0, ta_q[3:0]})
    else $error("precharge too soon after activate");
  a_rp_gap:
    assert property (cmd_issue.valid && !exit_cmd |-> pre_q >= {4'h0, ta_q[19:16]})
    else $error("command too soon after precharge");
  a_rc_gap:
    assert property (cmd_issue.valid && cmd_issue.cmd == ddr_timing_pkg::CMD_REFRESH
      |-> act_q >= {4'h0, ta_q[15:12]})
    else $error("refresh too soon after activate");
  a_rfc_gap:
    assert property (cmd_issue.valid && (cmd_issue.cmd == ddr_timing_pkg::CMD_REFRESH ||
      cmd_issue.cmd == ddr_timing_pkg::CMD_ACT) |-> ref_q >= {1'b0, rfc_q})
    else $error("command too soon after refresh");
endmodule : ddr2_config_timing_asserts

bind ddr2_config_timing_regs ddr2_config_timing_asserts #(.LAT_DEPTH(LAT_DEPTH)) u_asserts (
  .clk(clk),
  .reset_n(reset_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .cmd_req(cmd_req),
  .cmd_issue(cmd_issue),
  .read_data_due(read_data_due),
  .geometry(geometry)
);

// File: ddr_mem_model.sv
// memory-side model: stamps the first arrival of each command and of read data
module ddr_mem_model (
  input wire logic clk,
  input wire logic clear,
  input wire ddr_timing_pkg::cmd_req_t cmd_issue,
  input wire logic read_data_due,
  output int stamp [0:15]
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (clear)
      foreach (stamp[i]) stamp[i] = -1;
    else
    begin
      if (cmd_issue.valid && stamp[cmd_issue.cmd] < 0)
        stamp[cmd_issue.cmd] = cyc;
      if (read_data_due && stamp[15] < 0)
        stamp[15] = cyc;
    end
  end
endmodule : ddr_mem_model

// File: testbench.sv
// self-checking bench for the ddr2 configuration and timing block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear = 1'b0;
  ddr_timing_pkg::reg_req_t reg_req = '0;
  ddr_timing_pkg::cmd_req_t cmd_req = '0;
  ddr_timing_pkg::cmd_req_t cmd_issue;
  ddr_timing_pkg::geometry_t geometry;
  logic [31:0] reg_rdata;
  logic read_data_due;
  int stamp [0:15];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h0df9;
  logic [31:0] m [0:4];
  logic [31:0] wm [0:4];
  always #5 clk = ~clk;
  ddr2_config_timing_regs u_ddr2_config_timing_regs (.clk(clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cmd_req(cmd_req), .cmd_issue(cmd_issue),
    .read_data_due(read_data_due), .geometry(geometry));
  ddr_mem_model u_ddr_mem_model (.clk(clk), .clear(clear), .cmd_issue(cmd_issue),
    .read_data_due(read_data_due), .stamp(stamp));
  function automatic logic [31:0] geo_exp(input logic [31:0] v);
    return {5'h0, ddr_timing_pkg::COL_BASE + {3'h0, v[1:0]},
      ddr_timing_pkg::ROW_BASE + {3'h0, v[3:2]}, v[6:4], v[7], v[8], v[9], v[11:10],
      v[14:12], v[16], v[17], v[20], v[21], v[22], v[23]};
  endfunction : geo_exp
  function automatic logic [31:0] f(input int r, input int lsb, input int w);
    return (m[r] >> lsb) & ((32'h1 << w) - 32'h1);
  endfunction : f
  function automatic logic [7:0] adr(input int i);
    return (i == 5) ? 8'h18 : 8'(4 * i);
  endfunction : adr
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    if (a < 8'h14)
      m[a[4:2]] = d & wm[a[4:2]];
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = (a < 8'h14) ? m[a[4:2]] : 32'h0;
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    check("register read", reg_rdata, e);
  endtask : rd
  task automatic geo_chk();
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("geometry", {5'h0, geometry}, geo_exp(m[0]));
  endtask : geo_chk
  // first command is offered for one edge, the second is held until it arrives
  task automatic pair(input ddr_timing_pkg::cmd_t a, input ddr_timing_pkg::cmd_t b,
    input logic [31:0] exp);
    int k;
    repeat (40) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    cmd_req <= '{valid: 1'b1, cmd: a, bank: 3'h1};
    @(posedge clk);
    cmd_req <= '{valid: 1'b1, cmd: b, bank: 3'h2};
    k = 0;
    while (stamp[b] < 0 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cmd_req <= '0;
    check("command gap", 32'(stamp[b] - stamp[a]), exp);
    repeat (10) @(negedge clk);
    if (a == ddr_timing_pkg::CMD_READ || b == ddr_timing_pkg::CMD_READ)
      check("read due", 32'(stamp[15] - stamp[ddr_timing_pkg::CMD_READ]), f(0, 4, 3) + 32'h1);
  endtask : pair
  // activates held back to back: the fifth waits for the oldest window slot
  task automatic faw_run(input int span);
    int n;
    n = 0;
    repeat (40) @(posedge clk);
    cmd_req <= '{valid: 1'b1, cmd: ddr_timing_pkg::CMD_ACT, bank: 3'h3};
    @(posedge clk);
    repeat (span) @(negedge clk) n = n + int'(cmd_issue.valid);
    check("activates in window", 32'(n), 32'h4);
    @(negedge clk);
    check("fifth activate", {31'h0, cmd_issue.valid}, 32'h1);
    @(posedge clk);
    cmd_req <= '0;
  endtask : faw_run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    results();
  end
  initial
  begin
    m = '{ddr_timing_pkg::RST_GEOMETRY, ddr_timing_pkg::RST_TIMING_A,
      ddr_timing_pkg::RST_TIMING_B, ddr_timing_pkg::RST_TIMING_C, ddr_timing_pkg::RST_CONTROL};
    wm = '{ddr_timing_pkg::GEO_WMASK, 32'hffffffff, ddr_timing_pkg::TB_WMASK,
      ddr_timing_pkg::TC_WMASK, 32'h1};
    repeat (10) @(posedge clk);
    check("geometry in reset", {5'h0, geometry}, 32'h0);
    reset_n <= 1'b1;
    geo_chk();
    for (int i = 0; i < 6; i++)
      rd(adr(i));
    $display("test reset values done");
    for (int j = 0; j < 4; j++)
    begin
      for (int i = 0; i < 6; i++)
        wr(adr(i), $random(seed));
      for (int i = 0; i < 6; i++)
        rd(adr(i));
      geo_chk();
    end
    $display("test register access done");
    wr(8'h00, 32'h00107039);
    geo_chk();
    wr(8'h00, 32'h00100039);
    geo_chk();
    wr(8'h04, 32'h73629435);
    wr(8'h08, 32'h04140c08);
    wr(8'h0c, 32'h00104365);
    wr(8'h10, 32'h0);
    $display("test driver calibration done");
    pair(ddr_timing_pkg::CMD_ACT, ddr_timing_pkg::CMD_READ, f(1, 4, 4));
    pair(ddr_timing_pkg::CMD_ACT, ddr_timing_pkg::CMD_PRE, f(1, 0, 4));
    pair(ddr_timing_pkg::CMD_PRE, ddr_timing_pkg::CMD_ACT, f(1, 16, 4));
    pair(ddr_timing_pkg::CMD_WRITE, ddr_timing_pkg::CMD_READ, f(1, 24, 3));
    pair(ddr_timing_pkg::CMD_ACT, ddr_timing_pkg::CMD_REFRESH, f(1, 12, 4));
    pair(ddr_timing_pkg::CMD_LOAD_MODE, ddr_timing_pkg::CMD_ACT, f(1, 28, 4));
    pair(ddr_timing_pkg::CMD_PD_EXIT, ddr_timing_pkg::CMD_READ, f(2, 24, 4));
    pair(ddr_timing_pkg::CMD_SELFREF_EXIT, ddr_timing_pkg::CMD_WRITE, f(2, 8, 8));
    pair(ddr_timing_pkg::CMD_SELFREF_EXIT, ddr_timing_pkg::CMD_READ, f(2, 16, 8));
    pair(ddr_timing_pkg::CMD_REFRESH, ddr_timing_pkg::CMD_ACT, f(2, 0, 7));
    pair(ddr_timing_pkg::CMD_READ, ddr_timing_pkg::CMD_PRE, f(3, 12, 3));
    pair(ddr_timing_pkg::CMD_PRE_ALL, ddr_timing_pkg::CMD_ACT, f(3, 8, 4));
    pair(ddr_timing_pkg::CMD_ACTIVE_PD_EXIT, ddr_timing_pkg::CMD_READ, f(3, 0, 4));
    wr(8'h10, 32'h1);
    pair(ddr_timing_pkg::CMD_ACTIVE_PD_EXIT, ddr_timing_pkg::CMD_READ, f(3, 4, 4));
    wr(8'h04, 32'h70629435);
    pair(ddr_timing_pkg::CMD_WRITE, ddr_timing_pkg::CMD_READ, 32'h2);
    wr(8'h04, 32'h78629435);
    pair(ddr_timing_pkg::CMD_WRITE, ddr_timing_pkg::CMD_READ, 32'h1);
    $display("test command spacing done");
    wr(8'h04, 32'h78129435);
    faw_run(f(3, 16, 8));
    $display("test activate window done");
    results();
  end
endmodule : testbench
